//--- logic/ahpd_top.sv
// host pin decode: chip selects, role strap, read strobe gating, dma ready
`timescale 1ns/100ps
`default_nettype none
module ahpd_top #(
  parameter int DATA_W = ahpd_pkg::DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              cs1_n,
  input  wire logic              cs3_n,
  input  wire logic              iord_n,
  input  wire logic              iowr_n,
  input  wire logic              hdmardy_n,
  input  wire logic              csel,
  input  wire logic              udma_rd_act,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              burst_valid,
  input  wire logic [DATA_W-1:0] burst_data,
  output logic                   role_slave,
  output logic                   role_valid,
  output ahpd_pkg::ahpd_sel_t    acc_sel,
  output logic                   acc_rd,
  output logic                   acc_wr,
  output logic [DATA_W-1:0]      dd_out,
  output logic                   dd_oe_n,
  output logic                   burst_ready,
  output logic                   csel_pullup
);
  ahpd_pkg::ahpd_strb_t strb;
  logic                 csel_lvl;
  logic                 cs1_lvl;
  logic                 cs3_lvl;
  logic                 rd_lvl;
  logic                 wr_lvl;
  logic                 rdy_lvl;

  // pins are asynchronous to core_clk, so each passes its own synchroniser;
  // strobes idle high and an open strap floats high through the pull-up,
  // so every stage resets to one and no false edge follows reset
  localparam int NPIN = 6;
  logic [NPIN-1:0]      pin_raw;
  wire logic [NPIN-1:0] pin_lvl;

  // bit order of the pin vector: chip selects low, strap on top
  assign pin_raw = {csel, hdmardy_n, iowr_n, iord_n, cs3_n, cs1_n};

  // one synchroniser per pin
  for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
    ahpd_sync #(
      .RST_VAL(1'b1)
    ) u_sync (
      .core_clk(core_clk),
      .nrst    (nrst),
      .pin     (pin_raw[gi]),
      .level   (pin_lvl[gi])
    );
  end

  assign {csel_lvl, rdy_lvl, wr_lvl, rd_lvl, cs3_lvl, cs1_lvl} = pin_lvl;

  // strobes turn active high once synchronised
  always_comb begin
    strb.cs1  = ~cs1_lvl;
    strb.cs3  = ~cs3_lvl;
    strb.rd   = ~rd_lvl;
    strb.wr   = ~wr_lvl;
    strb.hrdy = ~rdy_lvl;
  end

  // chip selects and strobes decode into the register that is accessed;
  // a select with no strobe selects nothing
  function automatic ahpd_pkg::ahpd_sel_t sel_of(input ahpd_pkg::ahpd_strb_t s);
    ahpd_pkg::ahpd_sel_t r;
    r = ahpd_pkg::AHPD_SEL_NONE;
    // both selects low at once is refused and selects nothing
    if (s.cs3 && !s.cs1 && s.rd) begin
      r = ahpd_pkg::AHPD_SEL_ALTSTAT;
    end else if (s.cs3 && !s.cs1 && s.wr) begin
      r = ahpd_pkg::AHPD_SEL_DEVCTL;
    end else if (s.cs1 && !s.cs3 && (s.rd || s.wr)) begin
      r = ahpd_pkg::AHPD_SEL_TASK;
    end
    return r;
  endfunction

  // role strap sampling: wait for synchroniser to fill, then latch once
  ahpd_pkg::ahpd_role_st_t role_st_r;
  ahpd_pkg::ahpd_role_st_t role_st_nxt;
  logic [1:0]              wait_r;
  logic [1:0]              wait_nxt;
  logic                    role_r;
  logic                    role_nxt;
  logic                    role_valid_r;
  logic                    role_valid_nxt;

  // the wait covers the synchroniser fill after reset, so the strap is
  // read only once its level has passed all three stages; reading it
  // earlier would latch the reset value of the stages instead of the pin
  always_comb begin
    role_st_nxt    = role_st_r;
    wait_nxt       = wait_r;
    role_nxt       = role_r;
    role_valid_nxt = role_valid_r;
    case (role_st_r)
      ahpd_pkg::AHPD_ROLE_WAIT: begin
        wait_nxt = wait_r - 2'h1;
        if (wait_r == 2'h0) begin
          role_st_nxt = ahpd_pkg::AHPD_ROLE_SAMP;
        end
      end
      ahpd_pkg::AHPD_ROLE_SAMP: begin
        // grounded reads low: master; open reads high: slave
        role_nxt       = csel_lvl ? ahpd_pkg::ROLE_SLAVE : ahpd_pkg::ROLE_MASTER;
        role_valid_nxt = 1'b1;
        role_st_nxt    = ahpd_pkg::AHPD_ROLE_HELD;
      end
      default: begin
        // later strap changes are ignored on purpose
        role_st_nxt = ahpd_pkg::AHPD_ROLE_HELD;
      end
    endcase
  end

  // role registers; reset returns to slave, the level an open strap gives
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      role_st_r    <= ahpd_pkg::AHPD_ROLE_WAIT;
      wait_r       <= ahpd_pkg::SYNC_RST;
      role_r       <= ahpd_pkg::ROLE_SLAVE;
      role_valid_r <= 1'b0;
    end else begin
      role_st_r    <= role_st_nxt;
      wait_r       <= wait_nxt;
      role_r       <= role_nxt;
      role_valid_r <= role_valid_nxt;
    end
  end

  // access decode and data bus drive
  ahpd_pkg::ahpd_sel_t sel_r;
  ahpd_pkg::ahpd_sel_t sel_nxt;
  logic                acc_rd_r;
  logic                acc_rd_nxt;
  logic                acc_wr_r;
  logic                acc_wr_nxt;
  logic [DATA_W-1:0]   dd_r;
  logic [DATA_W-1:0]   dd_nxt;
  logic                oe_n_r;
  logic                oe_n_nxt;
  logic                brdy_r;
  logic                brdy_nxt;
  logic                chip_sel;

  // limitation: the drive follows the strobe through the synchroniser,
  // so it starts and stops five edges after the pin moves
  always_comb begin
    sel_nxt    = sel_of(strb);
    chip_sel   = strb.cs1 ^ strb.cs3;
    acc_rd_nxt = strb.rd && chip_sel && !udma_rd_act;
    acc_wr_nxt = strb.wr && chip_sel && !udma_rd_act;
    dd_nxt     = dd_r;
    oe_n_nxt   = ahpd_pkg::OE_FLOAT;
    brdy_nxt   = 1'b0;
    if (udma_rd_act) begin
      // burst data only while host ready; negation pauses the burst
      brdy_nxt = strb.hrdy;
      // a negated ready also floats the bus, so no word leaks during a pause
      if (strb.hrdy && burst_valid) begin
        dd_nxt   = burst_data;
        oe_n_nxt = ahpd_pkg::OE_DRIVE;
      end
    end else if (strb.rd && chip_sel) begin
      // host read strobe gates the bus drive
      dd_nxt   = rd_data;
      oe_n_nxt = ahpd_pkg::OE_DRIVE;
    end
  end

  // access registers; reset leaves the bus floated
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sel_r    <= ahpd_pkg::AHPD_SEL_NONE;
      acc_rd_r <= 1'b0;
      acc_wr_r <= 1'b0;
      dd_r     <= ahpd_pkg::DATA_RST;
      oe_n_r   <= ahpd_pkg::OE_FLOAT;
      brdy_r   <= 1'b0;
    end else begin
      sel_r    <= sel_nxt;
      acc_rd_r <= acc_rd_nxt;
      acc_wr_r <= acc_wr_nxt;
      dd_r     <= dd_nxt;
      oe_n_r   <= oe_n_nxt;
      brdy_r   <= brdy_nxt;
    end
  end

  // pull-up enable for the strap pin; left out of reset so the strap
  // reads high from the very first edge, even while nrst is held low
  logic pu_r;
  logic pu_nxt;

  always_comb begin
    pu_nxt = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    pu_r <= pu_nxt;
  end

  // every output comes straight from a flop
  assign role_slave  = role_r;
  assign role_valid  = role_valid_r;
  assign acc_sel     = sel_r;
  assign acc_rd      = acc_rd_r;
  assign acc_wr      = acc_wr_r;
  assign dd_out      = dd_r;
  assign dd_oe_n     = oe_n_r;
  assign burst_ready = brdy_r;
  assign csel_pullup = pu_r;
endmodule // ahpd_top
`default_nettype wire

//--- shared/ahpd_pkg.sv
// package: constants and carrier types for the host pin decode block
// What this block does
// - alternate chip select routes reads to alt status, writes to device control
// - role-select input is held high by an internal pull-up
// - role-select grounded means master, device 0
// - role-select open, reading high, means slave, device 1
// - outside ultra dma, read data is driven only while read strobe asserted; here the drive starts and stops five edges after the strobe pin moves
// - host may negate ready to pause; device stops until ready again
package ahpd_pkg;

  localparam int DATA_W = 16;
  localparam logic ROLE_MASTER = 1'b0;
  localparam logic ROLE_SLAVE = 1'b1;
  localparam logic OE_DRIVE = 1'b0;
  localparam logic OE_FLOAT = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [1:0] SYNC_RST = 2'h3;

  // register access selection decoded from the chip selects
  typedef enum logic [1:0] {
    AHPD_SEL_NONE    = 2'h0,
    AHPD_SEL_TASK    = 2'h1,
    AHPD_SEL_ALTSTAT = 2'h3,
    AHPD_SEL_DEVCTL  = 2'h2
  } ahpd_sel_t;

  // synchronised host strobes, active high after synchronisation
  typedef struct packed {
    logic cs1;
    logic cs3;
    logic rd;
    logic wr;
    logic hrdy;
  } ahpd_strb_t;

  // role sampling state
  typedef enum logic [1:0] {
    AHPD_ROLE_WAIT = 2'h0,
    AHPD_ROLE_SAMP = 2'h1,
    AHPD_ROLE_HELD = 2'h3
  } ahpd_role_st_t;

endpackage : ahpd_pkg

//--- logic/ahpd_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
`default_nettype none
module ahpd_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic pin,
  output var  logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;
  logic level_nxt;

  // change accepted only once stages two and three agree
  always_comb begin
    s1_nxt    = pin;
    s2_nxt    = s1_r;
    s3_nxt    = s2_r;
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      level_r <= RST_VAL;
    end else begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      s3_r    <= s3_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule // ahpd_sync
`default_nettype wire

//--- test/ahpd_host_model.sv
// host controller model: drives the host strobe pins
`timescale 1ns/100ps
`default_nettype none
module ahpd_host_model (
  input  wire ahpd_pkg::ahpd_strb_t req,
  input  wire logic                 core_clk,
  output var  logic                 cs1_n,
  output var  logic                 cs3_n,
  output var  logic                 iord_n,
  output var  logic                 iowr_n,
  output var  logic                 hdmardy_n
);
  // all pins idle (high) from time zero
  initial {cs1_n, cs3_n, iord_n, iowr_n, hdmardy_n} = 5'h1F;
  // pins move just after the falling edge, clear of sampling
  always @(negedge core_clk) begin
    cs1_n     <= !req.cs1;
    cs3_n     <= !req.cs3;
    iord_n    <= !req.rd;
    iowr_n    <= !req.wr;
    hdmardy_n <= !req.hrdy;
  end
endmodule // ahpd_host_model
`default_nettype wire

//--- test/ahpd_checker.sv
// port checker for the host pin decode block
`timescale 1ns/100ps
`default_nettype none
module ahpd_checker (
  input wire logic                core_clk,
  input wire logic                nrst,
  input wire logic                cs1_n,
  input wire logic                cs3_n,
  input wire logic                iord_n,
  input wire logic                iowr_n,
  input wire logic                hdmardy_n,
  input wire logic                csel,
  input wire logic                udma_rd_act,
  input wire logic                role_slave,
  input wire logic                role_valid,
  input wire ahpd_pkg::ahpd_sel_t acc_sel,
  input wire logic                dd_oe_n,
  input wire logic                burst_ready,
  input wire logic                csel_pullup
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // pins need six stable cycles to cross the synchroniser
  chk_alt_read: assert property ((!cs3_n && cs1_n && !iord_n && iowr_n && !udma_rd_act)[*6]
    |-> acc_sel == ahpd_pkg::AHPD_SEL_ALTSTAT) else $error("alt read");
  chk_ctl_write: assert property ((!cs3_n && cs1_n && iord_n && !iowr_n)[*6]
    |-> acc_sel == ahpd_pkg::AHPD_SEL_DEVCTL) else $error("ctl write");
  chk_pullup_on: assert property (csel_pullup) else $error("pull-up off");
  chk_role_mst: assert property ($rose(role_valid) && !csel |-> !role_slave)
    else $error("not master");
  chk_role_slv: assert property ($rose(role_valid) && csel |-> role_slave)
    else $error("not slave");
  chk_role_held: assert property (role_valid |=> role_valid && $stable(role_slave))
    else $error("role moved");
  chk_pio_gate: assert property ((iord_n && !udma_rd_act)[*6] |-> dd_oe_n)
    else $error("drive w/o read");
  chk_burst_go: assert property ((udma_rd_act && !hdmardy_n)[*6] |-> burst_ready)
    else $error("no burst");
  chk_burst_stop: assert property (hdmardy_n[*6] |-> !burst_ready)
    else $error("no pause");
  chk_burst_float: assert property ((udma_rd_act && hdmardy_n)[*6] |-> dd_oe_n)
    else $error("drive w/o ready");
  cov_pio: cover property (!dd_oe_n && !udma_rd_act);
  cov_burst: cover property (burst_ready && !dd_oe_n);
  cov_mst: cover property (role_valid && !role_slave);
endmodule // ahpd_checker
bind ahpd_top ahpd_checker i_ahpd_checker (.core_clk, .nrst, .cs1_n, .cs3_n, .iord_n,
  .iowr_n, .hdmardy_n, .csel, .udma_rd_act, .role_slave, .role_valid, .acc_sel,
  .dd_oe_n, .burst_ready, .csel_pullup);
`default_nettype wire

//--- test/test_ahpd_top.sv
// testbench for the host pin decode block
`timescale 1ns/100ps
`default_nettype none
module test_ahpd_top;
  logic                 core_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 csel = 1'b1;
  logic                 udma_rd_act = 1'b0;
  logic                 burst_valid = 1'b0;
  logic [15:0]          rd_data = 16'hA5C3;
  logic [15:0]          burst_data = 16'h3C5A;
  ahpd_pkg::ahpd_strb_t req = 5'h00;
  wire logic            cs1_n, cs3_n, iord_n, iowr_n, hdmardy_n;
  logic                 role_slave, role_valid, acc_rd, acc_wr, dd_oe_n;
  logic                 burst_ready, csel_pullup;
  ahpd_pkg::ahpd_sel_t  acc_sel;
  logic [15:0]          dd_out;
  int                   failures = 0, total_checks = 0, cyc = 0;

  ahpd_host_model i_ahpd_host_model (.req, .core_clk, .cs1_n, .cs3_n, .iord_n, .iowr_n,
    .hdmardy_n);
  ahpd_top i_ahpd_top (.core_clk, .nrst, .cs1_n, .cs3_n, .iord_n, .iowr_n, .hdmardy_n,
    .csel, .udma_rd_act, .rd_data, .burst_valid, .burst_data, .role_slave, .role_valid,
    .acc_sel, .acc_rd, .acc_wr, .dd_out, .dd_oe_n, .burst_ready, .csel_pullup);

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // pins follow req a cycle later, outputs five edges after that
  task automatic host(input logic [4:0] r);
    req <= r;
    repeat (8) @(negedge core_clk);
  endtask

  // strap is moved after latching; the role must not follow
  task automatic t_role(input logic strap);
    nrst <= 1'b0;
    csel <= strap;
    repeat (12) @(negedge core_clk);
    nrst <= 1'b1;
    repeat (12) @(negedge core_clk);
    check("role", 16'({role_valid, role_slave}), 16'({1'b1, strap}));
    check("pullup", 16'(csel_pullup), 16'h0001);
    csel <= ~strap;
    repeat (8) @(negedge core_clk);
    check("held", 16'(role_slave), 16'(strap));
  endtask

  // fields: sel, rd, wr, oe_n
  task automatic t_decode;
    host(5'h0C);
    check("alt", 16'({acc_sel, acc_rd, acc_wr, dd_oe_n}), 16'h001C);
    check("rdata", dd_out, rd_data);
    host(5'h08);
    check("no_rd", 16'(dd_oe_n), 16'h0001);
    host(5'h0A);
    check("ctl", 16'({acc_sel, acc_rd, acc_wr, dd_oe_n}), 16'h0013);
    rd_data <= 16'h5A3C;
    host(5'h14);
    check("task_rd", 16'({acc_sel, acc_rd, acc_wr, dd_oe_n}), 16'h000C);
    check("task_data", dd_out, 16'h5A3C);
    host(5'h12);
    check("task_wr", 16'({acc_sel, acc_rd, acc_wr, dd_oe_n}), 16'h000B);
    host(5'h04);
    check("no_cs", 16'({acc_sel, acc_rd, acc_wr, dd_oe_n}), 16'h0001);
    host(5'h1C);
    check("both", 16'({acc_sel, dd_oe_n}), 16'h0001);
    host(5'h00);
  endtask

  // pio read during the pause must stay off the bus as well
  task automatic t_udma;
    udma_rd_act <= 1'b1;
    burst_valid <= 1'b1;
    host(5'h01);
    check("burst", 16'({burst_ready, dd_oe_n}), 16'h0002);
    check("bdata", dd_out, burst_data);
    host(5'h0C);
    check("pause", 16'({burst_ready, acc_rd, dd_oe_n}), 16'h0001);
    host(5'h01);
    check("resume", 16'({burst_ready, dd_oe_n}), 16'h0002);
    burst_valid <= 1'b0;
    host(5'h01);
    check("no_word", 16'({burst_ready, dd_oe_n}), 16'h0003);
    host(5'h00);
    udma_rd_act <= 1'b0;
    burst_valid <= 1'b0;
  endtask

  // hang guard, far above the 168 cycles needed
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    t_role(1'b0);
    t_role(1'b1);
    t_decode();
    t_udma();
    final_report();
  end
endmodule // test_ahpd_top
`default_nettype wire
